// file: pixel_snapshot_fw_ram_control.sv
`timescale 1ns/100ps
`include "pixel_snapshot_regs.svh"
module pixel_snapshot_fw_ram_control
  import pixel_snapshot_pkg::*;
#(
  parameter int PIXELS = `SNAP_PIXELS
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic sclk_i,
  input wire logic ncs_b_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_b_o,
  input wire logic frame_start_i,
  input wire logic [7:0] pix_data_i,
  input wire logic pix_valid_i,
  input wire logic burst_rd_i,
  output logic [7:0] burst_data_o,
  input wire logic [7:0] fw_data_i,
  input wire logic fw_valid_i,
  output logic fw_ready_o,
  output logic nav_halt_o,
  output logic fw_loaded_o,
  output logic snap_ready_o,
  output logic crc_busy_o
);
  localparam int IW = $clog2(PIXELS);
  localparam logic [IW-1:0] LAST = IW'(PIXELS - 1);

  function automatic logic [IW-1:0] step(input logic [IW-1:0] v);
    return (v == LAST) ? '0 : v + 1'b1;
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input byte_t d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Link side: address byte then data byte, mode 3, frame reset by chip select
  logic [3:0] cnt_reg, cnt_next;
  byte_t shift_reg, shift_next, addr_reg, addr_next, tx_reg, tx_next;
  serial_cmd_s cmd_reg, cmd_next;
  logic tog_reg, tog_next, link_clr_reg;
  byte_t rd_data_reg, rd_data_next;

  always_comb begin
    cnt_next = cnt_reg + 4'h1;
    shift_next = {shift_reg[6:0], mosi_i};
    addr_next = addr_reg;
    cmd_next = cmd_reg;
    tog_next = tog_reg;
    if (cnt_reg == 4'h7) begin
      addr_next = shift_next;
      if (!shift_next[`WRITE_BIT]) begin
        cmd_next = '{wr: 1'b0, addr: shift_next[6:0], data: 8'h00};
        tog_next = ~tog_reg;
      end
    end
    if (cnt_reg == 4'hf && addr_reg[`WRITE_BIT]) begin
      cmd_next = '{wr: 1'b1, addr: addr_reg[6:0], data: shift_next};
      tog_next = ~tog_reg;
    end
  end

  always_ff @(posedge sclk_i or posedge ncs_b_i) begin
    if (ncs_b_i) begin
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
    end
  end

  // Held apart from the frame reset: clearing the toggle at frame end would fake an event
  always_ff @(posedge sclk_i or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      cmd_reg <= '0;
      tog_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      tog_reg <= tog_next;
    end
  end

  // Read data is quasi-static: the controller waits after the address byte before clocking on
  always_comb begin
    tx_next = {tx_reg[6:0], 1'b0};
    if (cnt_reg == 4'h8 && !addr_reg[`WRITE_BIT]) begin
      tx_next = rd_data_reg;
    end
  end

  always_ff @(negedge sclk_i or posedge ncs_b_i) begin
    if (ncs_b_i) begin
      tx_reg <= 8'h00;
    end else begin
      tx_reg <= tx_next;
    end
  end

  assign miso_o = tx_reg[7];
  assign miso_oe_b_o = ncs_b_i;

  // Core side: toggle crossing into a two-entry command buffer
  logic s1_reg, s2_reg, s3_reg, seen_reg, seen_next;
  serial_cmd_s fifo_reg [2];
  logic wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0] cnt2_reg, cnt2_next;
  logic in_valid, in_ready, out_valid, out_ready, take;
  serial_cmd_s cmd;

  assign in_valid = (s2_reg == s3_reg) && (s3_reg != seen_reg);
  assign in_ready = cnt2_reg != 2'd2;
  assign out_valid = cnt2_reg != 2'd0;
  assign cmd = fifo_reg[rp_reg];
  assign take = out_valid && out_ready;

  always_comb begin
    seen_next = seen_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt2_next = cnt2_reg;
    if (in_valid && in_ready) begin
      seen_next = s3_reg;
      wp_next = ~wp_reg;
    end
    if (take) begin
      rp_next = ~rp_reg;
    end
    cnt2_next = cnt2_reg + 2'(in_valid && in_ready) - 2'(take);
  end

  always_ff @(posedge mclk_i) begin
    s1_reg <= tog_reg;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    link_clr_reg <= !rst_b_i;
    if (in_valid && in_ready) begin
      fifo_reg[wp_reg] <= cmd_reg;
    end
    if (!rst_b_i) begin
      seen_reg <= s3_reg;
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt2_reg <= 2'd0;
    end else begin
      seen_reg <= seen_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt2_reg <= cnt2_next;
    end
  end

  // Snapshot, firmware and CRC engine over one flip-flop RAM
  snap_state_e state_reg, state_next;
  byte_t ram_reg [PIXELS];
  logic [IW-1:0] ptr_reg, ptr_next, cap_reg, cap_next, fw_reg, fw_next, crc_idx_reg, crc_idx_next;
  logic [15:0] crc_reg, crc_next, dout_reg, dout_next, crc_step;
  byte_t misc_reg, misc_next, plo_reg, plo_next, burst_reg, burst_next;
  byte_t ram_at_ptr, ram_at_crc, ram_wd;
  logic [IW-1:0] ram_wa;
  logic ram_we, halt_reg, halt_next, fwok_reg, fwok_next, wr_snap, rd_snap, crc_go;

  assign out_ready = state_reg != ST_CRC;
  assign ram_at_ptr = ram_reg[ptr_reg];
  assign ram_at_crc = ram_reg[crc_idx_reg];
  assign crc_step = crc_byte(crc_reg, ram_at_crc);
  assign wr_snap = take && cmd.wr && cmd.addr == `ADDR_SNAP;
  assign rd_snap = take && !cmd.wr && cmd.addr == `ADDR_SNAP;
  assign crc_go = take && cmd.wr && cmd.addr == `ADDR_FW_CTRL && cmd.data == `FW_CRC_CODE;
  assign fw_ready_o = state_reg == ST_IDLE && !fwok_reg;

  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    cap_next = cap_reg;
    fw_next = fw_reg;
    crc_idx_next = crc_idx_reg;
    crc_next = crc_reg;
    dout_next = dout_reg;
    misc_next = misc_reg;
    plo_next = plo_reg;
    halt_next = halt_reg;
    fwok_next = fwok_reg;
    rd_data_next = rd_data_reg;
    burst_next = 8'h00;
    ram_we = 1'b0;
    ram_wa = cap_reg;
    ram_wd = pix_data_i;
    if (wr_snap) begin
      halt_next = 1'b1;
      fwok_next = 1'b0;
      ptr_next = '0;
      state_next = (cmd.data == `SNAP_TRIGGER) ? ST_ARMED : ST_IDLE;
    end else if (crc_go) begin
      state_next = ST_CRC;
      crc_idx_next = '0;
      crc_next = `CRC_INIT;
    end else if (take && cmd.wr) begin
      unique case (cmd.addr)
        `ADDR_FW_CTRL: fw_next = '0;
        `ADDR_MISC_TWO: misc_next = cmd.data;
        `ADDR_PERIOD_LO: plo_next = cmd.data;
        default: ;
      endcase
    end
    if (take && !cmd.wr) begin
      unique case (cmd.addr)
        `ADDR_SNAP: begin
          // Written values are never stored, so only pixels or zero come back
          rd_data_next = (state_reg == ST_READY) ? ram_at_ptr : 8'h00;
          if (state_reg == ST_READY) begin
            ptr_next = step(ptr_reg);
          end
        end
        `ADDR_DOUT_LO: rd_data_next = dout_reg[7:0];
        `ADDR_DOUT_HI: rd_data_next = dout_reg[15:8];
        `ADDR_MISC_TWO: rd_data_next = misc_reg | 8'(1 << `MISC_FIXED_BIT);
        `ADDR_PERIOD_LO: rd_data_next = plo_reg;
        default: rd_data_next = 8'h00;
      endcase
    end
    // A serial read wins the pointer when both paths ask in one cycle
    if (burst_rd_i && !rd_snap && !wr_snap && state_reg == ST_READY) begin
      burst_next = ram_at_ptr;
      ptr_next = step(ptr_reg);
    end
    unique case (state_reg)
      ST_ARMED: begin
        if (frame_start_i && !wr_snap && !crc_go) begin
          state_next = ST_FILL;
          cap_next = '0;
        end
      end
      ST_FILL: begin
        if (pix_valid_i && !wr_snap && !crc_go) begin
          ram_we = 1'b1;
          cap_next = step(cap_reg);
          if (cap_reg == LAST) begin
            state_next = ST_READY;
            ptr_next = '0;
          end
        end
      end
      ST_CRC: begin
        crc_next = crc_step;
        crc_idx_next = step(crc_idx_reg);
        if (crc_idx_reg == LAST) begin
          dout_next = crc_step;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (fw_valid_i && fw_ready_o && !take) begin
          ram_we = 1'b1;
          ram_wa = fw_reg;
          ram_wd = fw_data_i;
          fw_next = step(fw_reg);
          fwok_next = fw_reg == LAST;
        end
      end
      ST_READY: ;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (ram_we) begin
      ram_reg[ram_wa] <= ram_wd;
    end
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      ptr_reg <= '0;
      cap_reg <= '0;
      fw_reg <= '0;
      crc_idx_reg <= '0;
      crc_reg <= `CRC_INIT;
      dout_reg <= `RST_DOUT;
      misc_reg <= `RST_MISC_TWO;
      plo_reg <= `RST_PERIOD_LO;
      halt_reg <= 1'b0;
      fwok_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      burst_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      cap_reg <= cap_next;
      fw_reg <= fw_next;
      crc_idx_reg <= crc_idx_next;
      crc_reg <= crc_next;
      dout_reg <= dout_next;
      misc_reg <= misc_next;
      plo_reg <= plo_next;
      halt_reg <= halt_next;
      fwok_reg <= fwok_next;
      rd_data_reg <= rd_data_next;
      burst_reg <= burst_next;
    end
  end

  assign burst_data_o = burst_reg;
  assign nav_halt_o = halt_reg;
  assign fw_loaded_o = fwok_reg;
  assign snap_ready_o = state_reg == ST_READY;
  assign crc_busy_o = state_reg == ST_CRC;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_trigger_arms: assert property (wr_snap && cmd.data == `SNAP_TRIGGER |=> state_reg == ST_ARMED)
    else $error("trigger write did not arm capture");
  chk_fill_ends: assert property (state_reg == ST_FILL && pix_valid_i && cap_reg == LAST && !take
    |=> snap_ready_o && ptr_reg == '0)
    else $error("last pixel did not finish snapshot");
  chk_write_halts: assert property (wr_snap |=> nav_halt_o && !fw_loaded_o ##1 nav_halt_o)
    else $error("capture write did not halt tracking");
  chk_halt_holds: assert property (nav_halt_o |=> nav_halt_o)
    else $error("tracking resumed without reset");
  chk_ptr_step: assert property (rd_snap && snap_ready_o |=> ptr_reg == step($past(ptr_reg)))
    else $error("register read did not advance pointer");
  chk_burst_shares: assert property (burst_rd_i && !rd_snap && snap_ready_o && !wr_snap
    |=> ptr_reg == step($past(ptr_reg)) && burst_data_o == $past(ram_at_ptr))
    else $error("burst read did not use shared pointer");
  chk_zero_unready: assert property (rd_snap && !snap_ready_o |=> rd_data_reg == 8'h00)
    else $error("unready capture read not zero");
  chk_read_pixel: assert property (rd_snap && snap_ready_o |=> rd_data_reg == $past(ram_at_ptr))
    else $error("capture read did not return pixel");
  chk_crc_result: assert property (crc_busy_o && crc_idx_reg == LAST
    |=> !crc_busy_o && dout_reg == $past(crc_step))
    else $error("crc result not stored at end");
  chk_crc_start: assert property (crc_go |=> crc_busy_o && crc_idx_reg == '0)
    else $error("test code did not start crc");

  cov_trigger: cover property (wr_snap && cmd.data == `SNAP_TRIGGER);
  cov_snap_ready: cover property (!snap_ready_o ##1 snap_ready_o);
  cov_crc_done: cover property (crc_busy_o ##1 !crc_busy_o);
  cov_fifo_full: cover property (cnt2_reg == 2'd2);
endmodule

// file: pixel_snapshot_regs.svh
// How it works
// - Writing the trigger code to the capture register stores the next complete 1536 pixels.
// - Any write to the capture register halts tracking and marks the firmware as lost.
// - Each read of the capture register while the snapshot is ready returns one pixel and advances the shared pointer.
// - Register reads and burst reads advance the same pointer.
// - Reading the capture register before the snapshot is ready returns zero.
// - The capture register keeps no written value; reads give zero or pixel data.
// - Writing the test code to the firmware RAM control starts a 16-bit CRC over the RAM.
`ifndef PIXEL_SNAPSHOT_REGS_SVH
`define PIXEL_SNAPSHOT_REGS_SVH
`define ADDR_DOUT_LO 7'h0c
`define ADDR_DOUT_HI 7'h0d
`define ADDR_SNAP 7'h13
`define ADDR_FW_CTRL 7'h14
`define ADDR_RSVD_A 7'h15
`define ADDR_MISC_TWO 7'h16
`define ADDR_PERIOD_LO 7'h19
`define RST_MISC_TWO 8'h34
`define RST_PERIOD_LO 8'h90
`define RST_DOUT 16'h0000
`define MISC_FIXED_BIT 2
`define WRITE_BIT 7
`define SNAP_TRIGGER 8'h83
`define FW_CRC_CODE 8'ha1
`define FW_PREP_CODE 8'h1d
`define SNAP_PIXELS 1536
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h1021
`endif

// file: pixel_snapshot_pkg.sv
package pixel_snapshot_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    byte_t data;
  } serial_cmd_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_FILL = 3'b010,
    ST_READY = 3'b011,
    ST_CRC = 3'b100
  } snap_state_e;
endpackage

// file: serial_host.sv
`timescale 1ns/100ps
module serial_host (
  output logic sclk_o,
  output logic ncs_b_o,
  output logic mosi_o,
  input wire logic miso_i
);
  localparam real HALF = 62.5;
  // An empty select pulse clears the frame logic, which has no other reset
  initial begin
    sclk_o = 1'b1;
    ncs_b_o = 1'b0;
    mosi_o = 1'b0;
    #10 ncs_b_o = 1'b1;
  end
  // Mode 3: data changes with the falling edge, device samples on the rising one
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = b[i];
      #HALF sclk_o = 1'b1;
      #HALF;
    end
  endtask
  // Released line shows the inverse so a stale bit is never mistaken for data
  task automatic end_frame();
    ncs_b_o = 1'b1;
    mosi_o = ~mosi_o;
    #300;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    ncs_b_o = 1'b0;
    #HALF send_byte({1'b1, a});
    send_byte(d);
    end_frame();
  endtask
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    ncs_b_o = 1'b0;
    #HALF send_byte({1'b0, a});
    // Read data crosses on wait time alone, so hold well past 60 ns
    #200;
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = ~mosi_o;
      #HALF sclk_o = 1'b1;
      d[i] = miso_i;
      #HALF;
    end
    end_frame();
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
`include "pixel_snapshot_regs.svh"
module tb_top;
  import pixel_snapshot_pkg::*;
  localparam int NPIX = 16;
  logic mclk_i, rst_b_i, sclk_i, ncs_b_i, mosi_i, miso_o, miso_oe_b_o, miso_line;
  logic frame_start_i, pix_valid_i, burst_rd_i, fw_valid_i, fw_ready_o;
  logic nav_halt_o, fw_loaded_o, snap_ready_o, crc_busy_o;
  logic [7:0] pix_data_i, burst_data_o, fw_data_i;
  int err_total = 0;
  int n_compared = 0;
  assign miso_line = miso_oe_b_o ? ~miso_o : miso_o;
  pixel_snapshot_fw_ram_control #(.PIXELS(NPIX)) i_pixel_snapshot_fw_ram_control (
    .mclk_i, .rst_b_i, .sclk_i, .ncs_b_i, .mosi_i, .miso_o, .miso_oe_b_o,
    .frame_start_i, .pix_data_i, .pix_valid_i, .burst_rd_i, .burst_data_o,
    .fw_data_i, .fw_valid_i, .fw_ready_o, .nav_halt_o, .fw_loaded_o,
    .snap_ready_o, .crc_busy_o);
  serial_host i_serial_host (.sclk_o(sclk_i), .ncs_b_o(ncs_b_i), .mosi_o(mosi_i),
    .miso_i(miso_line));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  function automatic byte_t fw_byte(input int i);
    return 8'hc3 ^ 8'(i * 7);
  endfunction
  function automatic byte_t pix(input int i);
    return 8'h20 + 8'(i * 3);
  endfunction
  function automatic logic [15:0] ref_crc();
    logic [15:0] c;
    c = `CRC_INIT;
    for (int i = 0; i < NPIX; i++) begin
      c = c ^ {fw_byte(i), 8'h00};
      for (int b = 0; b < 8; b++) begin
        c = c[15] ? ({c[14:0], 1'b0} ^ `CRC_POLY) : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction
  task automatic check(input string what, input byte_t exp, input byte_t got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic burst(output byte_t d);
    @(negedge mclk_i);
    burst_rd_i = 1'b1;
    @(negedge mclk_i);
    burst_rd_i = 1'b0;
    d = burst_data_o;
    @(negedge mclk_i);
  endtask
  task automatic t_regs();
    byte_t d;
    i_serial_host.read_reg(`ADDR_MISC_TWO, d);
    check("misc reset", `RST_MISC_TWO, d);
    i_serial_host.read_reg(`ADDR_PERIOD_LO, d);
    check("period reset", `RST_PERIOD_LO, d);
    i_serial_host.write_reg(`ADDR_PERIOD_LO, 8'h5a);
    i_serial_host.read_reg(`ADDR_PERIOD_LO, d);
    check("period rw", 8'h5a, d);
    i_serial_host.write_reg(`ADDR_MISC_TWO, 8'h3c);
    i_serial_host.read_reg(`ADDR_MISC_TWO, d);
    check("misc rw", 8'h3c, d);
    i_serial_host.read_reg(`ADDR_FW_CTRL, d);
    check("fw ctrl write only", 8'h00, d);
    i_serial_host.read_reg(`ADDR_RSVD_A, d);
    check("reserved", 8'h00, d);
    i_serial_host.read_reg(`ADDR_SNAP, d);
    check("snap not ready", 8'h00, d);
    $display("test regs done");
  endtask
  task automatic t_fw();
    byte_t d;
    logic [15:0] crc;
    i_serial_host.write_reg(`ADDR_FW_CTRL, `FW_PREP_CODE);
    @(negedge mclk_i);
    for (int i = 0; i < NPIX; i++) begin
      fw_valid_i = 1'b1;
      fw_data_i = fw_byte(i);
      for (int n = 0; n < 50 && fw_ready_o !== 1'b1; n++) @(negedge mclk_i);
      @(negedge mclk_i);
      // Stall the stream now and then so the handshake is exercised
      if (i % 4 == 3) begin
        fw_valid_i = 1'b0;
        @(negedge mclk_i);
      end
    end
    fw_valid_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    check("fw loaded", 8'h01, {7'h00, fw_loaded_o});
    check("fw full refuses", 8'h00, {7'h00, fw_ready_o});
    i_serial_host.write_reg(`ADDR_FW_CTRL, `FW_CRC_CODE);
    for (int n = 0; n < 5000 && crc_busy_o !== 1'b0; n++) @(negedge mclk_i);
    crc = ref_crc();
    i_serial_host.read_reg(`ADDR_DOUT_LO, d);
    check("crc lo", crc[7:0], d);
    i_serial_host.read_reg(`ADDR_DOUT_HI, d);
    check("crc hi", crc[15:8], d);
    $display("test firmware done");
  endtask
  task automatic t_capture();
    byte_t d;
    i_serial_host.write_reg(`ADDR_SNAP, `SNAP_TRIGGER);
    @(negedge mclk_i);
    check("nav halt", 8'h01, {7'h00, nav_halt_o});
    check("fw lost", 8'h00, {7'h00, fw_loaded_o});
    frame_start_i = 1'b1;
    @(negedge mclk_i);
    frame_start_i = 1'b0;
    for (int i = 0; i < NPIX; i++) begin
      pix_data_i = pix(i);
      pix_valid_i = 1'b1;
      @(negedge mclk_i);
      pix_valid_i = 1'b0;
      @(negedge mclk_i);
    end
    check("snap ready", 8'h01, {7'h00, snap_ready_o});
    i_serial_host.read_reg(`ADDR_SNAP, d);
    check("pixel 0", pix(0), d);
    i_serial_host.read_reg(`ADDR_SNAP, d);
    check("pixel 1", pix(1), d);
    for (int i = 2; i < NPIX; i++) begin
      burst(d);
      check("burst pixel", pix(i), d);
    end
    i_serial_host.read_reg(`ADDR_SNAP, d);
    check("pointer wrap", pix(0), d);
    i_serial_host.write_reg(`ADDR_SNAP, 8'h55);
    i_serial_host.read_reg(`ADDR_SNAP, d);
    check("snap keeps no write", 8'h00, d);
    burst(d);
    check("burst not ready", 8'h00, d);
    rst_b_i = 1'b0;
    repeat (8) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    check("nav restored", 8'h00, {7'h00, nav_halt_o});
    $display("test capture done");
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    conclude();
  end
  initial begin
    rst_b_i = 1'b0;
    frame_start_i = 1'b0;
    pix_valid_i = 1'b0;
    pix_data_i = 8'h00;
    burst_rd_i = 1'b0;
    fw_valid_i = 1'b0;
    fw_data_i = 8'h00;
    repeat (8) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    t_regs();
    t_fw();
    t_capture();
    conclude();
  end
endmodule
